// *** cmd_frame_pkg.sv ***
// Constants, state type and rule summary for the command frame interpreter
// What this block does
// - Command core is command, type, motor/bank byte, then four value bytes MSB first.
// - Serial and USB frames wrap the core in an address byte and checksum byte.
// - Checksum is the 8-bit sum of all earlier frame bytes, address included.
// - CAN frames carry no address or checksum byte; identifier and CRC replace them.
// - Serial reply is reply address, module address, status, command, value, checksum.
// - Reply checksum is the 8-bit sum of the other eight reply bytes.
// - CAN replies drop the reply address and checksum bytes; identifier is the reply address.
// - Exactly one reply per host command to this module, sent only after execution has finished; stored-program commands get none.
// - Stay receiving; drive the bus only for a reply to a received command.
// - Status 100 means executed; status 101 means stored into program memory.
// - Error statuses: 1 checksum, 2 command, 3 type, 4 value, 5 locked, 6 unavailable.
// - Commands held in program memory can run standalone without any host.
package cmd_frame_pkg;
	// ==========================================================
	// Frame layout
	localparam int        BYTE_W       = 8;
	localparam int        VAL_W        = 32;
	localparam int        CMD_W        = 56;
	localparam int        FRAME_W      = 64;
	localparam int        REPLY_W      = 72;
	localparam logic [3:0] IDX_SERIAL  = 4'h0;
	localparam logic [3:0] IDX_CAN     = 4'h1;
	localparam logic [3:0] IDX_LAST    = 4'h7;
	localparam logic [3:0] IDX_CSUM    = 4'h8;
	localparam logic [3:0] REPLY_SER   = 4'h9;
	localparam logic [3:0] REPLY_CAN   = 4'h7;
	// ==========================================================
	// Status codes and the stop command
	localparam logic [7:0] ST_OK       = 8'h64;
	localparam logic [7:0] ST_STORED   = 8'h65;
	localparam logic [7:0] ST_CSUM     = 8'h01;
	localparam logic [7:0] ST_BAD_CMD  = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] ST_BAD_VAL  = 8'h04;
	localparam logic [7:0] ST_LOCKED   = 8'h05;
	localparam logic [7:0] ST_NOT_AVL  = 8'h06;
	localparam logic [7:0] CMD_STOP    = 8'h1C;
	// ==========================================================
	// Timing and sizes
	localparam int        CLK_PERIOD_NS = 50;
	localparam int        GAP_TIME_US   = 100;
	localparam int        GAP_CYC       = (GAP_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int        FIFO_DEPTH    = 16;
	localparam int        PROG_AW       = 8;
	// ==========================================================
	// Sequencer states, Gray along idle-receive-execute-reply
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_RX    = 3'b001,
		S_EXEC  = 3'b011,
		S_WAIT  = 3'b010,
		S_TX    = 3'b110,
		S_STORE = 3'b111,
		S_FETCH = 3'b101,
		S_LOAD  = 3'b100
	} seq_state_e;
endpackage : cmd_frame_pkg

// *** byte_stream_if.sv ***
// Valid/ready stream carrier between the interpreter and its FIFO
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// *** stream_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic    clk,
	input wire logic    rst,
	// Streams
	byte_stream_if.snk  wr,
	byte_stream_if.src  rd
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign wr.ready = (cnt_r != DEPTH[AW:0]);
	assign rd.valid = (cnt_r != '0);
	assign rd.data  = mem[rp_r];
	assign push     = wr.valid & wr.ready;
	assign pop      = rd.valid & rd.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= wr.data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule : stream_fifo

// *** prog_mem.sv ***
// Program memory for stored commands, registered read data
`timescale 1ns/1ps
module prog_mem #(
	parameter int AW = 8,
	parameter int DW = 56
) (
	// Clock
	input wire logic          clk,
	// Write port
	input wire logic          we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic     [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : prog_mem

// *** cmd_frame_interp.sv ***
// Command frame receiver, checker, executor handshake and reply generator
`timescale 1ns/1ps
module cmd_frame_interp #(
	parameter int GAP_CYCLES = cmd_frame_pkg::GAP_CYC,
	parameter int DEPTH      = cmd_frame_pkg::FIFO_DEPTH,
	parameter int PAW        = cmd_frame_pkg::PROG_AW
) (
	// Clock and reset
	input wire logic                               mclk,
	input wire logic                               rst,
	// Link configuration
	input wire logic                               can_mode,
	input wire logic [cmd_frame_pkg::BYTE_W-1:0]   module_addr,
	input wire logic [cmd_frame_pkg::BYTE_W-1:0]   reply_addr,
	// Received byte stream
	input wire logic                               rx_valid,
	input wire logic [cmd_frame_pkg::BYTE_W-1:0]   rx_data,
	output logic                                   rx_ready,
	// Reply byte stream and bus driver enable
	output logic                                   tx_valid,
	output logic [cmd_frame_pkg::BYTE_W-1:0]       tx_data,
	input wire logic                               tx_ready,
	output logic                                   tx_drive,
	// Execution handshake
	output logic                                   exec_valid,
	output logic [cmd_frame_pkg::BYTE_W-1:0]       exec_cmd,
	output logic [cmd_frame_pkg::BYTE_W-1:0]       exec_type,
	output logic [cmd_frame_pkg::BYTE_W-1:0]       exec_bank,
	output logic [cmd_frame_pkg::VAL_W-1:0]        exec_value,
	input wire logic                               exec_done,
	input wire logic [cmd_frame_pkg::BYTE_W-1:0]   exec_status,
	input wire logic [cmd_frame_pkg::VAL_W-1:0]    exec_result,
	// Program memory control and frame drop flag
	input wire logic                               prog_store,
	input wire logic                               run_start,
	input wire logic                               run_stop,
	output logic                                   running,
	output logic                                   frame_dropped
);
	import cmd_frame_pkg::*;

	// ==========================================================
	// Declarations
	seq_state_e            state_r;
	logic [3:0]            idx_r;
	logic [FRAME_W-1:0]    frame_r;
	logic [BYTE_W-1:0]     sum_r;
	logic                  csum_bad_r;
	logic [15:0]           gap_r;
	logic [REPLY_W-1:0]    reply_r;
	logic [3:0]            left_r;
	logic                  from_prog_r;
	logic [PAW-1:0]        store_ptr_r;
	logic [PAW-1:0]        prog_len_r;
	logic [PAW-1:0]        pc_r;
	logic [CMD_W-1:0]      prog_rdata;
	logic                  pop;
	logic                  last_data;
	logic [BYTE_W-1:0]     byte_in;
	logic [BYTE_W-1:0]     reply_sum;
	logic [BYTE_W-1:0]     rstat;
	logic [VAL_W-1:0]      rval;
	logic                  csum_fail;
	logic                  reply_load;

	byte_stream_if #(.W(BYTE_W)) fin ();
	byte_stream_if #(.W(BYTE_W)) fout ();

	// ==========================================================
	// Receive buffer and program memory
	assign fin.valid  = rx_valid;
	assign fin.data   = rx_data;
	assign rx_ready   = fin.ready;
	assign fout.ready = (state_r == S_RX);

	stream_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_fifo (
		.clk (mclk),
		.rst (rst),
		.wr  (fin),
		.rd  (fout)
	);

	prog_mem #(.AW(PAW), .DW(CMD_W)) u_prog (
		.clk   (mclk),
		.we    (state_r == S_STORE),
		.waddr (store_ptr_r),
		.wdata (frame_r[CMD_W-1:0]),
		.raddr (pc_r),
		.rdata (prog_rdata)
	);

	assign pop       = fout.valid & fout.ready;
	assign byte_in   = fout.data;
	assign last_data = (idx_r == IDX_LAST);

	// ==========================================================
	// Reply checksum over the eight leading reply bytes
	function automatic logic [7:0] sum8(input logic [63:0] b);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++) begin
			s = s + b[i*8 +: 8];
		end
		return s;
	endfunction : sum8

	// Checksum byte popped and wrong; the reply is built in this same cycle if the address byte matches
	assign csum_fail = pop && !can_mode && (idx_r == IDX_CSUM) && (byte_in != sum_r);
	assign rstat = (csum_bad_r || csum_fail) ? ST_CSUM : (prog_store ? ST_STORED : exec_status);
	assign rval  = (csum_bad_r || csum_fail || prog_store) ? frame_r[VAL_W-1:0] : exec_result;
	assign reply_sum = sum8({reply_addr, module_addr, rstat, frame_r[55:48], rval});

	// ==========================================================
	// Sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= S_IDLE;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (fout.valid) begin
						state_r <= S_RX;
					end else if (running) begin
						state_r <= S_FETCH;
					end
				end
				S_RX: begin
					if (gap_r == 16'(GAP_CYCLES)) begin
						state_r <= S_IDLE;
					end else if (pop && !can_mode && idx_r == IDX_CSUM) begin
						// frames for other modules end silently
						if (frame_r[63:56] != module_addr) begin
							state_r <= S_IDLE;
						end else if (byte_in != sum_r) begin
							state_r <= S_TX;
						end else if (prog_store) begin
							state_r <= S_STORE;
						end else begin
							state_r <= S_EXEC;
						end
					end else if (pop && can_mode && last_data) begin
						state_r <= prog_store ? S_STORE : S_EXEC;
					end
				end
				S_STORE: begin
					state_r <= S_TX;
				end
				S_EXEC: begin
					state_r <= S_WAIT;
				end
				S_WAIT: begin
					if (exec_done) begin
						state_r <= from_prog_r ? S_IDLE : S_TX;
					end
				end
				S_TX: begin
					if (tx_ready && left_r == 4'h1) begin
						state_r <= S_IDLE;
					end
				end
				S_FETCH: begin
					state_r <= S_LOAD;
				end
				S_LOAD: begin
					state_r <= S_EXEC;
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Frame capture and running checksum
	always_ff @(posedge mclk) begin
		if (rst) begin
			idx_r      <= IDX_SERIAL;
			frame_r    <= '0;
			sum_r      <= 8'h00;
			csum_bad_r <= 1'b0;
		end else if (state_r == S_IDLE) begin
			idx_r      <= can_mode ? IDX_CAN : IDX_SERIAL;
			sum_r      <= 8'h00;
			csum_bad_r <= 1'b0;
		end else if (state_r == S_LOAD) begin
			frame_r <= {8'h00, prog_rdata};
		end else if (pop) begin
			idx_r <= idx_r + 4'h1;
			if (idx_r != IDX_CSUM) begin
				frame_r <= {frame_r[FRAME_W-9:0], byte_in};
				sum_r   <= sum_r + byte_in;
			end else begin
				csum_bad_r <= (byte_in != sum_r);
			end
		end
	end

	// ==========================================================
	// Byte-gap timeout
	always_ff @(posedge mclk) begin
		if (rst) begin
			gap_r         <= 16'h0000;
			frame_dropped <= 1'b0;
		end else begin
			frame_dropped <= (state_r == S_RX) && (gap_r == 16'(GAP_CYCLES));
			if (state_r != S_RX || pop) begin
				gap_r <= 16'h0000;
			end else begin
				gap_r <= gap_r + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Execution handshake
	always_ff @(posedge mclk) begin
		if (rst) begin
			exec_valid <= 1'b0;
			exec_cmd   <= 8'h00;
			exec_type  <= 8'h00;
			exec_bank  <= 8'h00;
			exec_value <= 32'h0000_0000;
		end else begin
			if (state_r == S_EXEC) begin
				exec_valid <= 1'b1;
				exec_cmd   <= frame_r[55:48];
				exec_type  <= frame_r[47:40];
				exec_bank  <= frame_r[39:32];
				exec_value <= frame_r[VAL_W-1:0];
			end else if (exec_done) begin
				exec_valid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Reply shifter
	assign reply_load = (state_r == S_WAIT && exec_done && !from_prog_r) || (state_r == S_STORE)
			|| (csum_fail && frame_r[63:56] == module_addr);

	always_ff @(posedge mclk) begin
		if (rst) begin
			reply_r <= '0;
			left_r  <= 4'h0;
		end else if (reply_load) begin
			if (can_mode) begin
				reply_r <= {module_addr, rstat, frame_r[55:48], rval, 16'h0000};
				left_r  <= REPLY_CAN;
			end else begin
				reply_r <= {reply_addr, module_addr, rstat, frame_r[55:48], rval, reply_sum};
				left_r  <= REPLY_SER;
			end
		end else if (state_r == S_TX && tx_ready) begin
			reply_r <= {reply_r[REPLY_W-9:0], 8'h00};
			left_r  <= left_r - 4'h1;
		end
	end

	assign tx_valid = (state_r == S_TX);
	assign tx_drive = (state_r == S_TX);
	assign tx_data  = reply_r[REPLY_W-1 -: 8];

	// ==========================================================
	// Store pointer and standalone program counter
	always_ff @(posedge mclk) begin
		if (rst) begin
			store_ptr_r <= '0;
			prog_len_r  <= '0;
		end else if (!prog_store) begin
			store_ptr_r <= '0;
		end else if (state_r == S_STORE) begin
			store_ptr_r <= store_ptr_r + 1'b1;
			prog_len_r  <= store_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			running     <= 1'b0;
			pc_r        <= '0;
			from_prog_r <= 1'b0;
		end else begin
			if (state_r == S_FETCH) begin
				from_prog_r <= 1'b1;
			end else if (state_r == S_RX) begin
				from_prog_r <= 1'b0;
			end
			if (run_stop) begin
				running <= 1'b0;
			end else if (run_start && prog_len_r != '0) begin
				running <= 1'b1;
				pc_r    <= '0;
			end else if (state_r == S_WAIT && exec_done && from_prog_r) begin
				if (exec_cmd == CMD_STOP || pc_r + 1'b1 == prog_len_r) begin
					running <= 1'b0;
				end
				pc_r <= pc_r + 1'b1;
			end
		end
	end
endmodule : cmd_frame_interp

// *** cmd_frame_chk_sva.sv ***
// Port assertions for the command frame interpreter
`timescale 1ns/1ps
module cmd_frame_chk (
	// Clock, reset and mode
	input wire logic	mclk,
	input wire logic	rst,
	input wire logic	can_mode,
	// Streams
	input wire logic	rx_ready,
	input wire logic	tx_valid,
	input wire logic [7:0]	tx_data,
	input wire logic	tx_ready,
	input wire logic	tx_drive,
	// Execution and status
	input wire logic	exec_valid,
	input wire logic	exec_done,
	input wire logic	running,
	input wire logic	frame_dropped
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [3:0]	beats_r;
	// ==========
	// Accepted beats of the reply in flight
	always_ff @(posedge mclk) begin
		if (rst || !tx_valid)
			beats_r <= 4'h0;
		else if (tx_ready)
			beats_r <= beats_r + 4'h1;
	end
	// ==========
	// Properties
	property p_rst_quiet;
		$past(rst) |-> rx_ready && !tx_valid && !exec_valid && !running && !frame_dropped;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
	property p_drive;
		tx_drive == tx_valid;
	endproperty
	a_drive: assert property (p_drive) else $error("drive without reply");
	property p_exec_hold;
		exec_valid && !exec_done |=> exec_valid;
	endproperty
	a_exec_hold: assert property (p_exec_hold) else $error("exec dropped early");
	property p_exec_end;
		exec_valid && exec_done |=> !exec_valid;
	endproperty
	a_exec_end: assert property (p_exec_end) else $error("exec not ended");
	property p_reply_follows;
		exec_valid && exec_done && !running |=> tx_valid;
	endproperty
	a_reply_follows: assert property (p_reply_follows) else $error("no reply after exec");
	property p_no_tx_in_exec;
		exec_valid |-> !tx_valid;
	endproperty
	a_no_tx_in_exec: assert property (p_no_tx_in_exec) else $error("reply before exec end");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("reply byte changed");
	property p_reply_len;
		$fell(tx_valid) |-> beats_r == (can_mode ? 4'h7 : 4'h9);
	endproperty
	a_reply_len: assert property (p_reply_len) else $error("reply length wrong");
	property p_drop_pulse;
		frame_dropped |=> !frame_dropped;
	endproperty
	a_drop_pulse: assert property (p_drop_pulse) else $error("drop pulse too long");
endmodule : cmd_frame_chk
bind cmd_frame_interp cmd_frame_chk chk_u (.mclk, .rst, .can_mode, .rx_ready, .tx_valid, .tx_data, .tx_ready,
	.tx_drive, .exec_valid, .exec_done, .running, .frame_dropped);

// *** host_model.sv ***
// Host model: sends command bytes and collects reply bytes
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic	mclk,
	// Command bytes
	output logic	rx_valid,
	output logic [7:0]	rx_data,
	input wire logic	rx_ready,
	// Reply bytes
	input wire logic	tx_valid,
	input wire logic [7:0]	tx_data,
	output logic	tx_ready
);
	logic [7:0]	rep[$];
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// ==========
	// Each byte holds until taken; the released line shows its inverse
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			rx_valid <= 1'b1;
			rx_data <= b[i];
			do @(negedge mclk); while (!rx_ready);
			@(posedge mclk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~b[b.size()-1];
	endtask : send
	// ==========
	// Slow mode toggles ready to stall every other cycle
	task automatic recv(input int n, input bit slow);
		rep.delete();
		while (rep.size() < n) begin
			@(posedge mclk);
			tx_ready <= slow ? ~tx_ready : 1'b1;
			@(negedge mclk);
			if (tx_valid && tx_ready)
				rep.push_back(tx_data);
		end
		@(posedge mclk);
		tx_ready <= 1'b0;
	endtask : recv
endmodule : host_model

// *** cmd_frame_interp_tb.sv ***
// Self-checking testbench for the command frame interpreter
`timescale 1ns/1ps
module cmd_frame_interp_tb;
	import cmd_frame_pkg::*;
	localparam int	GAP = 20;
	logic	mclk, rst, can_mode, prog_store, run_start, run_stop;
	logic	rx_valid, rx_ready, tx_valid, tx_ready, tx_drive;
	logic	exec_valid, exec_done, running, frame_dropped;
	logic [7:0]	module_addr, reply_addr, rx_data, tx_data;
	logic [7:0]	exec_cmd, exec_type, exec_bank, exec_status;
	logic [31:0]	exec_value, exec_result;
	logic [7:0]	f[$];
	logic [7:0]	w[$];
	int	bad_count = 0;
	int	n_compared = 0;
	int	cyc = 0;
	bit	sent;
	cmd_frame_interp #(.GAP_CYCLES(GAP)) dut_u (.mclk, .rst, .can_mode, .module_addr, .reply_addr, .rx_valid,
		.rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .tx_drive, .exec_valid, .exec_cmd, .exec_type,
		.exec_bank, .exec_value, .exec_done, .exec_status, .exec_result, .prog_store, .run_start, .run_stop,
		.running, .frame_dropped);
	host_model host_u (.mclk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ==========
	// Shared checks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			$display("unexpected at %0t: run hung", $time);
			report_and_stop();
		end
	end
	task automatic mk(input logic [7:0] a, input logic [7:0] c, input logic [31:0] v);
		logic [7:0] s;
		f = {a, c, ~c, c ^ 8'h5A, v[31:24], v[23:16], v[15:8], v[7:0]};
		s = 8'h00;
		foreach (f[i]) s += f[i];
		f.push_back(s);
	endtask : mk
	task automatic chk_reply(input logic [7:0] st, input logic [7:0] c, input logic [31:0] v, input bit slow);
		logic [7:0] e[$];
		logic [7:0] s;
		e = {reply_addr, module_addr, st, c, v[31:24], v[23:16], v[15:8], v[7:0]};
		s = 8'h00;
		foreach (e[i]) s += e[i];
		e.push_back(s);
		if (can_mode)
			e = e[1:7];
		host_u.recv(e.size(), slow);
		foreach (e[i]) chk(host_u.rep[i], e[i], "reply byte");
	endtask : chk_reply
	task automatic serve(input logic [7:0] c, input logic [31:0] v, input logic [7:0] st, input int hold);
		int t;
		t = 0;
		do begin
			@(negedge mclk);
			t++;
		end while (exec_valid !== 1'b1 && t < 80);
		chk(exec_valid, 1'b1, "exec");
		chk({exec_cmd, exec_type, exec_bank}, {c, ~c, c ^ 8'h5A}, "fields");
		chk(exec_value, v, "value");
		repeat (hold) @(posedge mclk);
		@(posedge mclk);
		exec_done <= 1'b1;
		exec_status <= st;
		exec_result <= ~v;
		@(posedge mclk);
		exec_done <= 1'b0;
	endtask : serve
	task automatic quiet(input int n, input string m);
		int k;
		k = 0;
		repeat (n) begin
			@(negedge mclk);
			k += (tx_valid !== 1'b0) + (exec_valid !== 1'b0);
		end
		@(posedge mclk);
		chk(k, 0, m);
	endtask : quiet
	// ==========
	// Scenarios
	task automatic t_exec;
		logic [7:0] sts[6];
		sts = '{ST_OK, ST_BAD_CMD, ST_BAD_TYPE, ST_BAD_VAL, ST_LOCKED, ST_NOT_AVL};
		foreach (sts[i]) begin
			mk(module_addr, 8'h04 + 8'(i), 32'h1234_5678 << i);
			host_u.send(f);
			serve(f[1], {f[4], f[5], f[6], f[7]}, sts[i], i);
			chk_reply(sts[i], f[1], ~{f[4], f[5], f[6], f[7]}, i[0]);
		end
	endtask : t_exec
	task automatic t_badsum;
		mk(module_addr, 8'h05, 32'h8000_00FF);
		f[8] = f[8] + 8'h01;
		host_u.send(f);
		chk_reply(ST_CSUM, 8'h05, 32'h8000_00FF, 1'b0);
	endtask : t_badsum
	task automatic t_gap;
		int t;
		t = 0;
		mk(module_addr, 8'h06, 32'h0000_0001);
		host_u.send(f[0:2]);
		repeat (GAP + 20) begin
			@(negedge mclk);
			t += frame_dropped;
		end
		@(posedge mclk);
		chk(t, 1, "drop pulse");
		host_u.send(f);
		serve(8'h06, 32'h0000_0001, ST_OK, 2);
		chk_reply(ST_OK, 8'h06, ~32'h0000_0001, 1'b1);
	endtask : t_gap
	task automatic t_can;
		@(posedge mclk);
		can_mode <= 1'b1;
		@(posedge mclk);
		mk(module_addr, 8'h07, 32'hCAFE_0102);
		host_u.send(f[1:7]);
		serve(8'h07, 32'hCAFE_0102, ST_OK, 1);
		chk_reply(ST_OK, 8'h07, ~32'hCAFE_0102, 1'b0);
		@(posedge mclk);
		can_mode <= 1'b0;
	endtask : t_can
	task automatic t_store;
		prog_store <= 1'b1;
		mk(module_addr, 8'h08, 32'h0000_0ABC);
		host_u.send(f);
		chk_reply(ST_STORED, 8'h08, 32'h0000_0ABC, 1'b0);
		mk(module_addr, CMD_STOP, 32'h0000_0000);
		host_u.send(f);
		chk_reply(ST_STORED, CMD_STOP, 32'h0000_0000, 1'b0);
		prog_store <= 1'b0;
		run_start <= 1'b1;
		run_stop <= 1'b1;
		@(posedge mclk);
		run_start <= 1'b0;
		run_stop <= 1'b0;
		@(negedge mclk);
		chk(running, 1'b0, "stop wins");
		@(posedge mclk);
		run_start <= 1'b1;
		@(posedge mclk);
		run_start <= 1'b0;
		@(negedge mclk);
		chk(running, 1'b1, "run");
		serve(8'h08, 32'h0000_0ABC, ST_OK, 1);
		serve(CMD_STOP, 32'h0000_0000, ST_OK, 0);
		quiet(30, "standalone");
		chk(running, 1'b0, "run end");
	endtask : t_store
	task automatic t_fill;
		mk(module_addr + 8'h02, 8'h09, 32'h0000_0000);
		w = {f, f, f};
		mk(module_addr, 8'h09, 32'h0000_0010);
		host_u.send(f);
		sent = 1'b0;
		fork
			begin
				host_u.send(w);
				sent = 1'b1;
			end
		join_none
		repeat (40) @(negedge mclk);
		chk(rx_ready, 1'b0, "full");
		serve(8'h09, 32'h0000_0010, ST_OK, 0);
		chk_reply(ST_OK, 8'h09, ~32'h0000_0010, 1'b1);
		while (!sent) @(posedge mclk);
		quiet(60, "foreign frames");
	endtask : t_fill
	initial begin
		rst = 1'b1;
		can_mode = 1'b0;
		prog_store = 1'b0;
		run_start = 1'b0;
		run_stop = 1'b0;
		exec_done = 1'b0;
		exec_status = 8'h00;
		exec_result = 32'h0000_0000;
		module_addr = 8'h21;
		reply_addr = 8'h02;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_exec();
		t_badsum();
		t_gap();
		t_can();
		t_store();
		t_fill();
		report_and_stop();
	end
endmodule : cmd_frame_interp_tb
